// ===== design/term_ctrl_pkg.sv
package term_ctrl_pkg;

    // bus, pin, field and counter widths
    localparam int ADDR_W      = 12;
    localparam int BANK_W      = 2;
    localparam int WB_ADR_W    = 8;
    localparam int WB_DAT_W    = 32;
    localparam int WB_SEL_W    = 4;
    localparam int CL_W        = 4;
    localparam int BL_W        = 4;
    localparam int TERM_W      = 2;
    localparam int WIN_W       = 5;
    localparam int SNOOP_CNT_W = 8;

    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    localparam int CTRL_CL_LSB    = 0;
    localparam int CTRL_BL_LSB    = 4;
    localparam int CTRL_TERM_LSB  = 8;
    localparam int CTRL_SNOOP_BIT = 16;

    localparam int STAT_DUAL_BIT     = 0;
    localparam int STAT_CAPTURED_BIT = 1;
    localparam int STAT_OFF_BIT      = 2;
    localparam int STAT_HALF_BIT     = 3;
    localparam int STAT_STROBE_BIT   = 4;
    localparam int STAT_COUNT_LSB    = 8;
    localparam int STAT_WIN_LSB      = 16;

    // reset values
    localparam logic [CL_W-1:0]   CL_RESET    = 4'h7;
    localparam logic [BL_W-1:0]   BL_RESET    = 4'h4;
    localparam logic              SNOOP_RESET = 1'b1;

    // mode load op-code fields
    localparam int              MR_CL_LSB    = 4;
    localparam int              EMR_TERM_LSB = 2;
    localparam logic [BANK_W-1:0] BANK_MR    = 2'h0;
    localparam logic [BANK_W-1:0] BANK_EMR   = 2'h1;

    // timing counts, in clocks
    localparam logic [WIN_W-1:0] WIN_EXTRA  = 5'h02;
    localparam int               HIST_DEPTH = 14;
    localparam logic [CL_W-1:0]  CL_MIN     = 4'h2;

    // command codes on {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_LOAD = 3'h0;

    typedef enum logic [TERM_W-1:0] {
        TERM_OFF       = 2'h0,
        TERM_DUAL_120  = 2'h1,
        TERM_SINGLE_60 = 2'h2,
        TERM_RESERVED  = 2'h3
    } term_code_type;

    localparam term_code_type TERM_RESET = TERM_OFF;

    typedef enum logic [2:0] {
        STROBE_IDLE     = 3'b001,
        STROBE_PREAMBLE = 3'b010,
        STROBE_BURST    = 3'b100
    } strobe_state_type;

    function automatic logic is_cmd(input logic ras_n, input logic cas_n,
                                    input logic we_n, input logic [2:0] code);
        is_cmd = ({ras_n, cas_n, we_n} == code);
    endfunction

endpackage

// ===== design/snoop_if.sv
`timescale 1ns/1ps
interface snoop_if;
    import term_ctrl_pkg::*;
    logic              read_any;
    logic              read_self;
    logic              mode_load;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] op;

    modport decoder (output read_any, output read_self, output mode_load,
                     output bank, output op);
    modport core (input read_any, input read_self, input mode_load,
                  input bank, input op);
endinterface

// ===== design/snoop_decoder.sv
`timescale 1ns/1ps
module snoop_decoder
    import term_ctrl_pkg::*;
(
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            ce_i,
    input  wire logic                            cke_i,
    input  wire logic                            cs_n_i,
    input  wire logic                            ras_n_i,
    input  wire logic                            cas_n_i,
    input  wire logic                            we_n_i,
    input  wire logic [term_ctrl_pkg::BANK_W-1:0] ba_i,
    input  wire logic [term_ctrl_pkg::ADDR_W-1:0] addr_i,
    snoop_if.decoder                             evt
);
    logic              next_read_any;
    logic              next_read_self;
    logic              next_mode_load;
    logic [BANK_W-1:0] next_bank;
    logic [ADDR_W-1:0] next_op;

    always_comb begin
        // other rank's reads count too
        next_read_any  = cke_i & is_cmd(ras_n_i, cas_n_i, we_n_i, CMD_READ);
        next_read_self = next_read_any & ~cs_n_i;
        next_mode_load = cke_i & ~cs_n_i & is_cmd(ras_n_i, cas_n_i, we_n_i, CMD_LOAD);
        next_bank      = ba_i;
        next_op        = addr_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt.read_any  <= 1'b0;
            evt.read_self <= 1'b0;
            evt.mode_load <= 1'b0;
            evt.bank      <= '0;
            evt.op        <= '0;
        end else if (ce_i) begin
            evt.read_any  <= next_read_any;
            evt.read_self <= next_read_self;
            evt.mode_load <= next_mode_load;
            evt.bank      <= next_bank;
            evt.op        <= next_op;
        end
    end
endmodule

// ===== design/read_delay_line.sv
`timescale 1ns/1ps
module read_delay_line
    import term_ctrl_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire logic [1:0]                    event_i,
    input  wire logic [term_ctrl_pkg::CL_W-1:0] latency_i,
    output logic      [1:0]                    tap_o
);
    logic [1:0]      stage [HIST_DEPTH];
    logic [CL_W-1:0] idx;

    assign stage[0] = event_i;

    genvar g;
    generate
        for (g = 1; g < HIST_DEPTH; g++) begin : g_stage
            logic [1:0] next_stage;
            always_comb begin
                next_stage = stage[g-1];
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    stage[g] <= 2'h0;
                end else if (ce_i) begin
                    stage[g] <= next_stage;
                end
            end
        end
    endgenerate

    // tap is latency-2 after decode
    always_comb begin
        idx   = (latency_i < CL_MIN) ? 4'h0 : latency_i - CL_MIN;
        tap_o = stage[idx];
    end
endmodule

// ===== design/read_snoop_termination_control.sv
`timescale 1ns/1ps
module read_snoop_termination_control
    import term_ctrl_pkg::*;
(
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              ce_i,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [term_ctrl_pkg::WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [term_ctrl_pkg::WB_SEL_W-1:0] wb_sel_i,
    input  wire logic [term_ctrl_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic      [term_ctrl_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic                                   wb_ack_o,
    input  wire logic                              reset_pin_i,
    input  wire logic                              cke_i,
    input  wire logic                              cs_n_i,
    input  wire logic                              ras_n_i,
    input  wire logic                              cas_n_i,
    input  wire logic                              we_n_i,
    input  wire logic [term_ctrl_pkg::BANK_W-1:0]   ba_i,
    input  wire logic [term_ctrl_pkg::ADDR_W-1:0]   addr_i,
    output logic                                   die_termination_enable_o,
    output logic      [term_ctrl_pkg::TERM_W-1:0]   data_term_code_o,
    output logic                                   cmd_addr_term_en_o,
    output logic                                   addr_term_half_o,
    output logic                                   read_data_strobe_o,
    output logic                                   read_data_strobe_oe_n_o
);
    import term_ctrl_pkg::*;

    snoop_if evt();

    snoop_decoder u_decoder (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .cke_i   (cke_i),
        .cs_n_i  (cs_n_i),
        .ras_n_i (ras_n_i),
        .cas_n_i (cas_n_i),
        .we_n_i  (we_n_i),
        .ba_i    (ba_i),
        .addr_i  (addr_i),
        .evt     (evt.decoder)
    );

    // configuration
    logic [CL_W-1:0]  read_latency_cycles;
    logic [BL_W-1:0]  burst_count;
    term_code_type    term_code;
    logic             snoop_en;
    logic [CL_W-1:0]  next_read_latency_cycles;
    logic [BL_W-1:0]  next_burst_count;
    term_code_type    next_term_code;
    logic             next_snoop_en;

    // rank capture
    logic reset_pin_prev;
    logic rank_captured;
    logic rank_dual;
    logic next_reset_pin_prev;
    logic next_rank_captured;
    logic next_rank_dual;

    // termination window
    logic [WIN_W-1:0]       win_cnt;
    logic [SNOOP_CNT_W-1:0] snoop_count;
    logic                   next_die_term_en;
    logic [WIN_W-1:0]       next_win_cnt;
    logic [SNOOP_CNT_W-1:0] next_snoop_count;
    logic [WIN_W-1:0]       win_len;
    logic                   snoop_active;
    logic                   term_off;

    // read strobe
    strobe_state_type strobe_state;
    logic [BL_W-1:0]  beat_cnt;
    strobe_state_type next_strobe_state;
    logic [BL_W-1:0]  next_beat_cnt;
    logic             next_strobe;
    logic             next_strobe_oe_n;

    // bus slave
    logic                next_ack;
    logic [WB_DAT_W-1:0] next_dat;
    logic                wr_take;
    logic [WB_DAT_W-1:0] ctrl_word;
    logic [WB_DAT_W-1:0] status_word;
    logic [WB_DAT_W-1:0] ctrl_written;

    logic [1:0] tap;

    // snoops act only at dual load
    assign snoop_active = snoop_en & (term_code == TERM_DUAL_120);

    read_delay_line u_delay (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .event_i   ({evt.read_self, evt.read_any & snoop_active}),
        .latency_i (read_latency_cycles),
        .tap_o     (tap)
    );

    // configuration
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_CL_LSB +: CL_W]     = read_latency_cycles;
        ctrl_word[CTRL_BL_LSB +: BL_W]     = burst_count;
        ctrl_word[CTRL_TERM_LSB +: TERM_W] = term_code;
        ctrl_word[CTRL_SNOOP_BIT]          = snoop_en;
        ctrl_written = ctrl_word;
        for (int b = 0; b < WB_SEL_W; b++) begin
            if (wb_sel_i[b]) begin
                ctrl_written[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
        end
        wr_take = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
    end

    always_comb begin
        next_read_latency_cycles = read_latency_cycles;
        next_burst_count         = burst_count;
        next_term_code           = term_code;
        next_snoop_en            = snoop_en;
        if (wr_take && wb_adr_i == CTRL_OFFSET) begin
            next_read_latency_cycles = ctrl_written[CTRL_CL_LSB +: CL_W];
            next_burst_count         = ctrl_written[CTRL_BL_LSB +: BL_W];
            next_term_code           = term_code_type'(ctrl_written[CTRL_TERM_LSB +: TERM_W]);
            next_snoop_en            = ctrl_written[CTRL_SNOOP_BIT];
        end
        // mode loads win over a bus write
        if (evt.mode_load) begin
            if (evt.bank == BANK_MR) begin
                next_read_latency_cycles = evt.op[MR_CL_LSB +: CL_W];
            end else if (evt.bank == BANK_EMR) begin
                next_term_code = term_code_type'(evt.op[EMR_TERM_LSB +: TERM_W]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_latency_cycles <= CL_RESET;
            burst_count         <= BL_RESET;
            term_code           <= TERM_RESET;
            snoop_en            <= SNOOP_RESET;
        end else if (ce_i) begin
            read_latency_cycles <= next_read_latency_cycles;
            burst_count         <= next_burst_count;
            term_code           <= next_term_code;
            snoop_en            <= next_snoop_en;
        end
    end

    // rank capture
    always_comb begin
        next_reset_pin_prev = reset_pin_i;
        next_rank_captured  = rank_captured;
        next_rank_dual      = rank_dual;
        if (!rank_captured && !reset_pin_prev && reset_pin_i) begin
            next_rank_captured = 1'b1;
            next_rank_dual     = cke_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_pin_prev     <= 1'b1;
            rank_captured      <= 1'b0;
            rank_dual          <= 1'b0;
            addr_term_half_o   <= 1'b0;
            cmd_addr_term_en_o <= 1'b1;
        end else if (ce_i) begin
            reset_pin_prev     <= next_reset_pin_prev;
            rank_captured      <= next_rank_captured;
            rank_dual          <= next_rank_dual;
            addr_term_half_o   <= next_rank_captured & ~next_rank_dual;
            cmd_addr_term_en_o <= 1'b1;
        end
    end

    // termination window
    always_comb begin
        win_len          = WIN_W'({1'b0, burst_count[BL_W-1:1]}) + WIN_EXTRA;
        next_win_cnt     = (win_cnt != '0) ? win_cnt - 5'h01 : win_cnt;
        next_snoop_count = snoop_count;
        if (tap[0]) begin
            next_win_cnt = win_len;
        end
        if (evt.read_any) begin
            next_snoop_count = snoop_count + 8'h01;
        end
        next_die_term_en = (next_term_code != TERM_OFF) & (next_win_cnt == '0);
    end

    assign term_off = ~die_termination_enable_o & (term_code != TERM_OFF);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_cnt                  <= '0;
            snoop_count              <= '0;
            die_termination_enable_o <= 1'b0;
            data_term_code_o         <= TERM_RESET;
        end else if (ce_i) begin
            win_cnt                  <= next_win_cnt;
            snoop_count              <= next_snoop_count;
            die_termination_enable_o <= next_die_term_en;
            data_term_code_o         <= next_term_code;
        end
    end

    // read strobe
    always_comb begin
        next_strobe_state = strobe_state;
        next_beat_cnt     = beat_cnt;
        next_strobe       = read_data_strobe_o;
        next_strobe_oe_n  = 1'b1;
        case (strobe_state)
            STROBE_IDLE: begin
                next_strobe = 1'b0;
                if (tap[1]) begin
                    next_strobe_state = STROBE_PREAMBLE;
                    next_strobe       = 1'b1;
                    next_strobe_oe_n  = 1'b0;
                end
            end
            STROBE_PREAMBLE: begin
                next_strobe_state = STROBE_BURST;
                next_beat_cnt     = burst_count;
                next_strobe       = 1'b0;
                next_strobe_oe_n  = 1'b0;
            end
            STROBE_BURST: begin
                next_beat_cnt    = beat_cnt - 4'h2;
                next_strobe      = ~read_data_strobe_o;
                next_strobe_oe_n = 1'b0;
                if (beat_cnt <= 4'h2) begin
                    next_strobe_state = STROBE_IDLE;
                    next_strobe       = 1'b0;
                    next_strobe_oe_n  = 1'b1;
                end
            end
            default: begin
                next_strobe_state = STROBE_IDLE;
                next_strobe       = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_state            <= STROBE_IDLE;
            beat_cnt                <= '0;
            read_data_strobe_o      <= 1'b0;
            read_data_strobe_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            strobe_state            <= next_strobe_state;
            beat_cnt                <= next_beat_cnt;
            read_data_strobe_o      <= next_strobe;
            read_data_strobe_oe_n_o <= next_strobe_oe_n;
        end
    end

    // bus slave
    always_comb begin
        status_word = '0;
        status_word[STAT_DUAL_BIT]                 = rank_dual;
        status_word[STAT_CAPTURED_BIT]             = rank_captured;
        status_word[STAT_OFF_BIT]                  = term_off;
        status_word[STAT_HALF_BIT]                 = addr_term_half_o;
        status_word[STAT_STROBE_BIT]               = ~read_data_strobe_oe_n_o;
        status_word[STAT_COUNT_LSB +: SNOOP_CNT_W] = snoop_count;
        status_word[STAT_WIN_LSB +: WIN_W]         = win_cnt;
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = '0;
        if (next_ack && !wb_we_i) begin
            case (wb_adr_i)
                CTRL_OFFSET:   next_dat = ctrl_word;
                STATUS_OFFSET: next_dat = status_word;
                default:       next_dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end
endmodule

// ===== testbench/read_snoop_termination_control_properties.sv
`timescale 1ns/1ps
module read_snoop_termination_control_properties
    import term_ctrl_pkg::*;
(
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            ce_i,
    input  wire logic                            reset_pin_i,
    input  wire logic                            cke_i,
    input  wire logic                            cs_n_i,
    input  wire logic                            ras_n_i,
    input  wire logic                            cas_n_i,
    input  wire logic                            we_n_i,
    input  wire logic                            die_termination_enable_o,
    input  wire logic [term_ctrl_pkg::TERM_W-1:0] data_term_code_o,
    input  wire logic                            cmd_addr_term_en_o,
    input  wire logic                            addr_term_half_o,
    input  wire logic                            read_data_strobe_o,
    input  wire logic                            read_data_strobe_oe_n_o
);
    logic       rd;
    logic       own_rd;
    logic       code1;
    logic [3:0] gap;
    assign rd = ce_i && cke_i && ras_n_i && !cas_n_i && we_n_i;
    assign own_rd = rd && !cs_n_i;
    assign code1 = data_term_code_o == TERM_DUAL_120;
    // clocks since last read, saturates at 15
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap <= 4'hf;
        end else if (rd) begin
            gap <= 4'h0;
        end else if (ce_i && gap != 4'hf) begin
            gap <= gap + 4'h1;
        end
    end
    default clocking dck @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_cmd_term;
        cmd_addr_term_en_o;
    endproperty
    a_cmd_term: assert property (p_cmd_term) else $error("cmd termination off");
    property p_window_low;
        code1 && gap inside {[4'h6:4'h9]} |-> !die_termination_enable_o;
    endproperty
    a_window_low: assert property (p_window_low) else $error("window not off");
    property p_window_end;
        code1 && gap == 4'ha |-> die_termination_enable_o;
    endproperty
    a_window_end: assert property (p_window_end) else $error("window too long");
    property p_fall_cause;
        $fell(die_termination_enable_o) && code1 && $past(code1) |-> $past(rd, 7);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("off at wrong time");
    property p_single_on;
        data_term_code_o == TERM_SINGLE_60 && $past(data_term_code_o) == TERM_SINGLE_60
            |-> die_termination_enable_o;
    endproperty
    a_single_on: assert property (p_single_on) else $error("snoop acted at 60 ohm");
    property p_off_code;
        data_term_code_o == TERM_OFF && $past(data_term_code_o) == TERM_OFF
            |-> !die_termination_enable_o;
    endproperty
    a_off_code: assert property (p_off_code) else $error("enable with code off");
    property p_half_cause;
        $rose(addr_term_half_o) |-> $past(reset_pin_i) && !$past(cke_i);
    endproperty
    a_half_cause: assert property (p_half_cause) else $error("half uncaused");
    property p_half_hold;
        addr_term_half_o |=> addr_term_half_o;
    endproperty
    a_half_hold: assert property (p_half_hold) else $error("half setting lost");
    property p_preamble;
        $fell(read_data_strobe_oe_n_o) |-> read_data_strobe_o && $past(own_rd, 7)
            ##1 !read_data_strobe_o;
    endproperty
    a_preamble: assert property (p_preamble) else $error("strobe preamble wrong");
endmodule

bind read_snoop_termination_control read_snoop_termination_control_properties u_props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reset_pin_i(reset_pin_i), .cke_i(cke_i),
    .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
    .die_termination_enable_o(die_termination_enable_o), .data_term_code_o(data_term_code_o),
    .cmd_addr_term_en_o(cmd_addr_term_en_o), .addr_term_half_o(addr_term_half_o),
    .read_data_strobe_o(read_data_strobe_o), .read_data_strobe_oe_n_o(read_data_strobe_oe_n_o)
);

// ===== testbench/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model
    import term_ctrl_pkg::*;
(
    input  wire logic                       clk_i,
    output logic                            reset_pin_o,
    output logic                            cke_o,
    output logic [3:0]                      cmd_o,
    output logic [term_ctrl_pkg::BANK_W-1:0] ba_o,
    output logic [term_ctrl_pkg::ADDR_W-1:0] addr_o
);
    initial begin
        reset_pin_o = 1'b0;
        cke_o = 1'b1;
        cmd_o = 4'hf;
        ba_o = 2'h0;
        addr_o = 12'h000;
    end
    // one-clock command, then inverted deselect
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        cmd_o <= c;
        ba_o <= b;
        addr_o <= a;
        @(posedge clk_i);
        cmd_o <= 4'hf;
        ba_o <= ~b;
        addr_o <= ~a;
    endtask
    task automatic power_up(input logic lvl);
        reset_pin_o <= 1'b0;
        cke_o <= lvl;
        repeat (2) @(posedge clk_i);
        reset_pin_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        cke_o <= 1'b1;
    endtask
endmodule

// ===== testbench/read_snoop_termination_control_tb.sv
`timescale 1ns/1ps
module read_snoop_termination_control_tb;
    import term_ctrl_pkg::*;
    localparam int LO = int'(CL_RESET) - 1;
    localparam int HALF_BL = int'(BL_RESET) / 2;
    localparam int HI = LO + HALF_BL + 1;
    logic                clk_i;
    logic                rst_i;
    logic                ce;
    logic                wb_cyc, wb_stb, wb_we;
    logic [WB_ADR_W-1:0] wb_adr;
    logic [WB_SEL_W-1:0] wb_sel;
    logic [WB_DAT_W-1:0] wb_dat, wb_dat_o, q;
    logic                wb_ack_o, reset_pin, cke, term_en, cmd_term, half, strobe, strobe_oe_n;
    logic [3:0]          cmd;
    logic [BANK_W-1:0]   ba;
    logic [ADDR_W-1:0]   addr;
    logic [TERM_W-1:0]   term_code;
    int                  mismatches;
    int                  n_tests;
    int                  n_reads;
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    mem_ctrl_model mc (.clk_i(clk_i), .reset_pin_o(reset_pin), .cke_o(cke), .cmd_o(cmd),
        .ba_o(ba), .addr_o(addr));
    read_snoop_termination_control DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .reset_pin_i(reset_pin), .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
        .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr),
        .die_termination_enable_o(term_en), .data_term_code_o(term_code),
        .cmd_addr_term_en_o(cmd_term), .addr_term_half_o(half),
        .read_data_strobe_o(strobe), .read_data_strobe_oe_n_o(strobe_oe_n));
    function automatic logic [31:0] ctrl_word(input logic [1:0] term);
        ctrl_word = {15'h0, SNOOP_RESET, 6'h0, term, BL_RESET, CL_RESET};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                           input logic [3:0] sel);
        int i;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= d;
        wb_sel <= sel;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o;
        if (i == 20) begin
            check("wb_ack", 32'h1, 32'h0);
            close_out();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic watch(input int lo, input int hi, input logic own, input int n);
        int   k;
        logic drv;
        for (k = 1; k <= n; k++) begin
            @(posedge clk_i);
            #1;
            drv = own && k >= lo && k <= lo + HALF_BL;
            check("term_enable", 32'(!(k >= lo && k <= hi)), 32'(term_en));
            check("strobe_oe_n", 32'(!drv), 32'(strobe_oe_n));
            if (drv)
                check("strobe", 32'(k != lo + 1), 32'(strobe));
        end
        @(posedge clk_i);
    endtask
    task automatic t_reset();
        check("cmd_term", 32'h1, 32'(cmd_term));
        check("term_code", 32'(TERM_RESET), 32'(term_code));
        check("term_enable", 32'h0, 32'(term_en));
        wb_xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hf);
        check("ctrl", ctrl_word(TERM_RESET), q);
        $display("reset done");
    endtask
    task automatic t_rank();
        mc.power_up(1'b0);
        repeat (2) @(posedge clk_i);
        check("addr_half", 32'h1, 32'(half));
        wb_xfer(1'b0, STATUS_OFFSET, 32'h0, 4'hf);
        check("rank", 32'h2, 32'(q[1:0]));
        do_reset();
        mc.power_up(1'b1);
        mc.power_up(1'b0);
        repeat (2) @(posedge clk_i);
        check("addr_half", 32'h0, 32'(half));
        check("cmd_term", 32'h1, 32'(cmd_term));
        wb_xfer(1'b0, STATUS_OFFSET, 32'h0, 4'hf);
        check("rank", 32'h3, 32'(q[1:0]));
        $display("rank done");
    endtask
    task automatic t_mode(input logic [1:0] term);
        mc.cmd(4'h0, BANK_MR, 12'(CL_RESET) << MR_CL_LSB);
        mc.cmd(4'h0, BANK_EMR, 12'(term) << EMR_TERM_LSB);
        repeat (2) @(posedge clk_i);
        check("term_code", 32'(term), 32'(term_code));
        wb_xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hf);
        check("ctrl", ctrl_word(term), q);
        $display("mode done");
    endtask
    task automatic t_snoop(input logic own);
        mc.cmd({~own, CMD_READ}, 2'h0, 12'h0a5);
        n_reads++;
        watch(LO, HI, own, HI + 3);
        $display("snoop done");
    endtask
    task automatic t_extend();
        mc.cmd({1'b1, CMD_READ}, 2'h1, 12'h05a);
        repeat (2) @(posedge clk_i);
        mc.cmd({1'b1, CMD_READ}, 2'h2, 12'h3c3);
        n_reads += 2;
        watch(LO - 3, HI, 1'b0, HI + 3);
        $display("extend done");
    endtask
    task automatic t_code();
        t_mode(TERM_SINGLE_60);
        mc.cmd({1'b1, CMD_READ}, 2'h0, 12'h111);
        n_reads++;
        watch(HI + 1, HI, 1'b0, HI + 3);
        wb_xfer(1'b1, CTRL_OFFSET, ctrl_word(TERM_OFF), 4'hf);
        repeat (2) @(posedge clk_i);
        check("term_code", 32'(TERM_OFF), 32'(term_code));
        check("term_enable", 32'h0, 32'(term_en));
        wb_xfer(1'b1, CTRL_OFFSET, 32'h0000_0100, 4'h2);
        wb_xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hf);
        check("ctrl", ctrl_word(TERM_DUAL_120), q);
        $display("code done");
    endtask
    task automatic t_regs();
        wb_xfer(1'b1, STATUS_OFFSET, 32'h0, 4'hf);
        wb_xfer(1'b0, STATUS_OFFSET, 32'h0, 4'hf);
        check("rank", 32'h3, 32'(q[1:0]));
        check("read_count", 32'(n_reads), 32'(q[15:8]));
        wb_xfer(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
        wb_xfer(1'b0, 8'h08, 32'h0, 4'hf);
        check("unmapped", 32'h0, q);
        $display("regs done");
    endtask
    initial begin
        mismatches = 0;
        n_tests = 0;
        n_reads = 0;
        rst_i = 1'b1;
        ce = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
        do_reset();
        t_reset();
        t_rank();
        t_mode(TERM_DUAL_120);
        t_snoop(1'b1);
        t_snoop(1'b0);
        t_extend();
        t_code();
        t_regs();
        close_out();
    end
endmodule
